//--- inc/cvkul_pkg.sv
// package: addresses, field constants and access carrier for the key unlock
package cvkul_pkg;

  // register addresses
  localparam logic [15:0] DIE_REVISION_ADDR    = 16'hE707;
  localparam logic [15:0] UNLOCK_KEY_ADDR      = 16'hE7FE;
  localparam logic [15:0] ACCURACY_SET_ADDR    = 16'hE90C;
  localparam logic [15:0] LAST_ADDR_ADDR       = 16'hE9FE;
  localparam logic [15:0] LAST_DATA_ADDR       = 16'hE9FF;
  localparam logic [15:0] WAVE_FIRST_ADDR      = 16'hE880;
  localparam logic [15:0] WAVE_LAST_ADDR       = 16'hE89F;

  // key values and reset values
  localparam logic [7:0]  UNLOCK_KEY_VALUE     = 8'hAD;
  localparam logic [7:0]  RELOCK_KEY_VALUE     = 8'h00;
  localparam logic [15:0] ACCURACY_SET_RESET   = 16'h0000;
  localparam logic [15:0] LAST_ADDR_RESET      = 16'h0000;
  localparam logic [31:0] LAST_DATA_RESET      = 32'h0000_0000;
  localparam logic [7:0]  BUS_ERROR_DATA       = 8'h00;

  // revision that carries the burst skew, and the size of the skew
  localparam logic [7:0]  SKEW_REVISION        = 8'h01;
  localparam logic [15:0] SKEW_STEP            = 16'h0001;

  // one register access, issued by the serial port front end
  typedef struct packed {
    logic        valid;   // one-cycle strobe
    logic        write;   // 1 write, 0 read
    logic        burst;   // access is part of an spi burst
    logic        is_i2c;  // access came over i2c
    logic [15:0] addr;
    logic [31:0] wdata;
  } cvkul_req_s;

  // answer to a read, one cycle after the request
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } cvkul_rsp_s;

  // unlock sequencer states
  typedef enum logic [2:0] {
    KEY_IDLE   = 3'b001,
    KEY_ARMED  = 3'b010,
    KEY_STORED = 3'b100
  } cvkul_key_e;

endpackage : cvkul_pkg

//--- hdl/cvkul_regs.sv
// register bank: die revision, access capture and keyed setting location
//
// Contract
// - 8-bit read-only die revision register at 0xE707
// - reads record last address and returned data
// - revision one burst spi waveform reads skew address
// - i2c waveform reads record correct address and data
// - 0xAD to key location unlocks next write
// - 16-bit setting write stored while unlocked
// - zero to key location relocks setting location
// - setting read returns the value written
//
// behaviour notes
// - one access a cycle at most; valid is a one-cycle strobe from the
//   serial front end, which already runs on ref_clk, so no synchroniser
//   stands in front of req
// - reads answer through rsp, registered on the taking edge itself; writes
//   get no answer at all
// - rsp.rdata holds the last read word until the next read, so a slow
//   front end may pick it up late
// - the last-access pair sits at 0xE9FE and 0xE9FF; reading it does not
//   recapture, or the host could never see what it read before
// - capture happens on reads only; a write leaves the pair untouched,
//   so a host that relies on writes to clear a skew must read instead
// - the burst skew copies revision-one behaviour on purpose, so host
//   code written for that silicon sees the same values; a later read
//   outside the waveform window records correctly again
// - i2c reads and plain spi reads never skew, whatever the revision
// - the skewed capture records the data of the wrong address too; the
//   waveform window itself is not mapped here and reads as zero
// - the key sequencer drops the unlock on any access that breaks the
//   order; the third access relocks whatever it is, trading strictness
//   for the guarantee that the location never stays open
// - a key write with any other value leaves the location locked
// - writes to the die revision are ignored, it has no storage
// - the unlocked flag is registered so the metering core sees a clean
//   level, changing on the same edge as the setting itself
// - unmapped reads return zero rather than stalling the port
// - no long counters: every decision is made in the cycle of access
`timescale 1ns/1ps
module cvkul_regs
  import cvkul_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01  // arbitrary, not a real part code
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // access from the serial port front end
  input  wire cvkul_pkg::cvkul_req_s req,
  // read answer
  output cvkul_pkg::cvkul_rsp_s      rsp,
  // setting location as seen by the metering core
  output logic [15:0]               accuracy_setting,
  output logic                      setting_unlocked
);
  import cvkul_pkg::*;

  cvkul_key_e  key_r,      key_nxt;
  logic [15:0] setting_r,  setting_nxt;
  logic [15:0] last_addr_r, last_addr_nxt;
  logic [31:0] last_data_r, last_data_nxt;
  cvkul_rsp_s  rsp_r,      rsp_nxt;
  logic        unlocked_r, unlocked_nxt;

  // true for the waveform sample window
  function automatic logic is_wave(input logic [15:0] a);
    is_wave = (a >= WAVE_FIRST_ADDR) && (a <= WAVE_LAST_ADDR);
  endfunction : is_wave

  // write to the key location carrying a given low byte
  function automatic logic is_key_write(input cvkul_req_s r,
                                        input logic [7:0] v);
    is_key_write = r.valid && r.write && (r.addr == UNLOCK_KEY_ADDR) &&
                   (r.wdata[7:0] == v);
  endfunction : is_key_write

  // address recorded for a read; revision one skews burst wave reads
  function automatic logic [15:0] capture_addr(input cvkul_req_s r);
    capture_addr = r.addr;
    if (REVISION == SKEW_REVISION && r.burst && !r.is_i2c &&
        is_wave(r.addr)) begin
      capture_addr = 16'(r.addr + SKEW_STEP);
    end
  endfunction : capture_addr

  // read mux, shared by answer and capture
  function automatic logic [31:0] read_mux(input logic [15:0] a,
                                           input logic [15:0] s,
                                           input logic [15:0] la,
                                           input logic [31:0] ld);
    unique case (a)
      DIE_REVISION_ADDR: read_mux = {24'h000000, REVISION};
      ACCURACY_SET_ADDR: read_mux = {16'h0000, s};
      LAST_ADDR_ADDR:    read_mux = {16'h0000, la};
      LAST_DATA_ADDR:    read_mux = ld;
      default:           read_mux = {24'h000000, BUS_ERROR_DATA};
    endcase
  endfunction : read_mux

  // key sequencer: any other access between steps drops the unlock
  always_comb begin
    key_nxt     = key_r;
    setting_nxt = setting_r;
    if (req.valid) begin
      unique case (key_r)
        KEY_IDLE: begin
          // only the exact key value arms, anything else stays locked
          if (is_key_write(req, UNLOCK_KEY_VALUE)) begin
            key_nxt = KEY_ARMED;
          end
        end
        KEY_ARMED: begin
          if (req.write && req.addr == ACCURACY_SET_ADDR) begin
            setting_nxt = req.wdata[15:0];
            key_nxt     = KEY_STORED;
          end else begin
            key_nxt = KEY_IDLE;
          end
        end
        KEY_STORED: begin
          // relock on zero, and on anything else too, so it never stays open
          key_nxt = KEY_IDLE;
        end
        default: key_nxt = KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      key_r     <= KEY_IDLE;
      setting_r <= ACCURACY_SET_RESET;
    end else begin
      key_r     <= key_nxt;
      setting_r <= setting_nxt;
    end
  end

  // unlocked flag follows the sequencer's next state, so it rises on
  // the arming edge and leaves on the edge of the next access
  always_comb begin
    unlocked_nxt = (key_nxt == KEY_ARMED);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unlocked_r <= 1'h0;
    end else begin
      unlocked_r <= unlocked_nxt;
    end
  end

  // read answer: one-cycle strobe, data held until the next read
  always_comb begin
    rsp_nxt.valid = req.valid && !req.write;
    rsp_nxt.rdata = rsp_r.rdata;
    if (req.valid && !req.write) begin
      rsp_nxt.rdata = read_mux(req.addr, setting_r, last_addr_r,
                               last_data_r);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // communication verification capture, reads only
  always_comb begin
    logic [15:0] cap_addr;
    cap_addr      = capture_addr(req);
    last_addr_nxt = last_addr_r;
    last_data_nxt = last_data_r;
    // verification registers themselves are not recaptured
    if (req.valid && !req.write && req.addr != LAST_ADDR_ADDR &&
        req.addr != LAST_DATA_ADDR) begin
      last_addr_nxt = cap_addr;
      // data of the recorded address, wrong on purpose when skewed
      last_data_nxt = read_mux(cap_addr, setting_r, last_addr_r,
                               last_data_r);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_addr_r <= LAST_ADDR_RESET;
      last_data_r <= LAST_DATA_RESET;
    end else begin
      last_addr_r <= last_addr_nxt;
      last_data_r <= last_data_nxt;
    end
  end

  // outputs straight from flip-flops
  assign rsp              = rsp_r;
  assign accuracy_setting = setting_r;
  assign setting_unlocked = unlocked_r;

endmodule : cvkul_regs

//--- dv/cvkul_monitor.sv
// assertion checker of the keyed register bank
`timescale 1ns/1ps
module cvkul_monitor
  import cvkul_pkg::*;
#(parameter logic [7:0] REVISION = 8'h01) (
  // watched ports
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire cvkul_pkg::cvkul_req_s req,
  input wire cvkul_pkg::cvkul_rsp_s rsp,
  input wire logic [15:0]           accuracy_setting,
  input wire logic                  setting_unlocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // access decodes shared by the properties
  wire        rd  = req.valid & !req.write;
  wire        wr  = req.valid & req.write;
  wire        st  = req.addr == 16'hE90C;
  wire        rv  = req.addr == 16'hE707;
  wire [15:0] wl  = req.wdata[15:0];
  wire        ky  = wr & (req.addr == 16'hE7FE);
  wire        arm = ky & (wl[7:0] == 8'hAD);
  wire        ul  = setting_unlocked;
  // high after a stored setting until the next access, when a key
  // write relocks instead of arming
  logic       stored_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stored_r <= 1'h0;
    end else if (req.valid) begin
      stored_r <= ul & wr & st;
    end
  end
  property p_rev; rd && rv |=> rsp.rdata == 32'(REVISION); endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_ans; rd |=> rsp.valid; endproperty
  a_ans: assert property (p_ans) else $error("no read answer");
  property p_key; arm && !ul && !stored_r |=> ul; endproperty
  a_key: assert property (p_key) else $error("key did not arm");
  property p_set; wr && st && ul |=> accuracy_setting==$past(wl); endproperty
  a_set: assert property (p_set) else $error("setting not stored");
  property p_rlk; ky && wl[7:0] == 8'h00 |=> !ul; endproperty
  a_rlk: assert property (p_rlk) else $error("no relock");
  property p_rbk; rd && st |=> rsp.rdata[15:0]==accuracy_setting; endproperty
  a_rbk: assert property (p_rbk) else $error("bad setting read");
  property p_lck; wr && st && !ul |=> $stable(accuracy_setting); endproperty
  a_lck: assert property (p_lck) else $error("locked write taken");
  property p_drp; ul && req.valid && !arm |=> !ul; endproperty
  a_drp: assert property (p_drp) else $error("unlock kept");
endmodule : cvkul_monitor
bind cvkul_regs cvkul_monitor #(.REVISION(REVISION)) u_mon (
  .ref_clk(ref_clk), .nrst(nrst), .req(req), .rsp(rsp),
  .accuracy_setting(accuracy_setting), .setting_unlocked(setting_unlocked));

//--- dv/cvkul_host.sv
// host model issuing register accesses
`timescale 1ns/1ps
module cvkul_host
  import cvkul_pkg::*;
(
  // clock and answer in, access and hang flag out
  input  wire logic             ref_clk,
  input  cvkul_pkg::cvkul_rsp_s rsp,
  output cvkul_pkg::cvkul_req_s req = '0,
  output logic                  hung = 1'h0
);
  // one access a call, calls may follow edge after edge
  task automatic put(input logic w, input logic [1:0] m,
    input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'h1, w, m[1], m[0], a, d};
  endtask : put
  // drop the strobe after a run of accesses
  task automatic idle();
    @(posedge ref_clk);
    req.valid <= 1'h0;
  endtask : idle
  // read, then wait a bounded time so a dead port cannot hang us
  task automatic get(input logic [1:0] m, input logic [15:0] a,
    output logic [31:0] q);
    put(1'h0, m, a, 32'h0);
    idle();
    #1;
    for (int n = 0; n < 3 && rsp.valid !== 1'h1; n++) @(posedge ref_clk) #1;
    hung = rsp.valid !== 1'h1;
    q = rsp.rdata;
  endtask : get
endmodule : cvkul_host

//--- dv/testbench.sv
// self-checking bench of the keyed register bank
`timescale 1ns/1ps
module testbench;
  import cvkul_pkg::*;
  // bus modes: plain spi, spi burst, i2c
  localparam logic [1:0] SPI = 2'h0, BUR = 2'h2, I2C = 2'h1;
  logic        ref_clk = 1'h0;
  logic        nrst = 1'h0;
  cvkul_req_s  req;
  cvkul_rsp_s  rsp;
  logic        hung;
  logic [31:0] q;
  logic [15:0] setting;
  logic        unlocked;
  int          failures = 0;
  int          tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  cvkul_regs #(.REVISION(8'h01)) uut (.ref_clk(ref_clk), .nrst(nrst),
    .req(req), .rsp(rsp), .accuracy_setting(setting),
    .setting_unlocked(unlocked));
  cvkul_host host (.ref_clk(ref_clk), .rsp(rsp), .req(req), .hung(hung));
  // read a register and compare with the expected word
  task automatic rdc(input logic [1:0] m, input logic [15:0] a,
    input logic [31:0] e);
    host.get(m, a, q);
    tests_run++;
    if (q !== e) begin
      failures++;
      $display("[FAIL] reg %h expected %h seen %h", a, e, q);
    end
  endtask : rdc
  // compare a top-level output with the expected word
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // revision survives a write; its read is captured
  task automatic t_rev();
    host.put(1'h1, SPI, 16'hE707, 32'h55);
    host.idle();
    rdc(SPI, 16'hE707, 32'h01);
    rdc(SPI, LAST_ADDR_ADDR, 32'hE707);
    rdc(SPI, LAST_DATA_ADDR, 32'h01);
  endtask : t_rev
  // waveform reads: burst spi skews, i2c at the top edge does not
  task automatic t_wave();
    host.get(BUR, 16'hE885, q);
    rdc(SPI, LAST_ADDR_ADDR, 32'hE886);
    rdc(SPI, LAST_DATA_ADDR, {24'h000000, BUS_ERROR_DATA});
    host.get(BUR | I2C, 16'hE89F, q);
    rdc(SPI, LAST_ADDR_ADDR, 32'hE89F);
    host.get(SPI, 16'hE707, q);
    rdc(SPI, LAST_ADDR_ADDR, 32'hE707);
  endtask : t_wave
  // key, setting and relock back to back
  task automatic t_key(input logic [31:0] k, v, e);
    host.put(1'h1, SPI, 16'hE7FE, k);
    host.put(1'h1, SPI, 16'hE90C, v);
    #1;
    chk("unlocked", 32'(k[7:0] == UNLOCK_KEY_VALUE), 32'(unlocked));
    host.put(1'h1, SPI, 16'hE7FE, 32'h0);
    host.idle();
    rdc(SPI, 16'hE90C, e);
    chk("setting", e, 32'(setting));
    chk("relocked", 32'h0, 32'(unlocked));
  endtask : t_key
  // a read between key and setting drops the unlock
  task automatic t_brk();
    host.put(1'h1, SPI, 16'hE7FE, 32'hAD);
    host.get(SPI, 16'hE707, q);
    host.put(1'h1, SPI, 16'hE90C, 32'h1234);
    host.idle();
    rdc(SPI, 16'hE90C, 32'h3BD);
  endtask : t_brk
  // counts and verdict
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // a missing read answer ends the run
  always @(posedge hung) begin
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    t_rev();
    t_wave();
    t_key(32'hAD, 32'h3BD, 32'h3BD);
    t_key(32'h5A, 32'h1234, 32'h3BD);
    t_brk();
    wrap_up();
  end
endmodule : testbench
